// [core/fpc_pkg.sv]
// Shared opcodes, field layouts and counts for the pattern and correction register commands
package fpc_pkg;

  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_PATTERN = 8'h4A;
  localparam logic [7:0] OP_READ_PATTERN = 8'h41;
  localparam logic [7:0] OP_WRITE_CORR = 8'hB5;
  localparam logic [7:0] OP_READ_CORR = 8'hB3;
  localparam logic [7:0] OP_CLEAR_CORR = 8'hB6;
  localparam logic [7:0] OP_DIE_READ = 8'h13;
  localparam logic [7:0] OP_DTR_READ = 8'hED;

  // ---------------------------------------------------------------
  // Frame counts, in bit units (one per clock single-line, four in quad); dummy and pattern counts in clocks
  // ---------------------------------------------------------------
  localparam logic [5:0] BYTE_BITS = 6'h08;
  localparam logic [5:0] DATA_BITS = 6'h10;
  localparam logic [5:0] ADDR_END = 6'h28;
  localparam logic [5:0] CNT_SAT = 6'h38;
  localparam logic [5:0] STEP_SPI = 6'h01;
  localparam logic [5:0] STEP_QUAD = 6'h04;
  localparam logic [3:0] DUMMY_CLKS = 4'h8;
  localparam logic [3:0] PATTERN_CLKS = 4'h4;
  localparam logic [3:0] DM_WIN_LO = DUMMY_CLKS - PATTERN_CLKS + 4'h1;
  localparam logic [3:0] DM_MAX = 4'hF;

  // ---------------------------------------------------------------
  // Data lines
  // ---------------------------------------------------------------
  localparam int SI_LINE = 0;
  localparam int SO_LINE = 1;
  localparam logic [3:0] SI_MASK = 4'h1;
  localparam logic [3:0] SO_MASK = 4'h2;
  localparam logic [3:0] ALL_LINES = 4'hF;

  // ---------------------------------------------------------------
  // Correction register layout and reset values
  // ---------------------------------------------------------------
  localparam int CORR_EVENT_BIT = 1;
  localparam int CORR_CNT_LSB = 2;
  localparam int CORR_CNT_W = 3;
  localparam int CORR_ADDR_LSB = 5;
  localparam int CORR_ADDR_W = 2;
  localparam logic [7:0] CORR_STICKY = 8'h7E;
  localparam logic [7:0] CORR_RESET = 8'h00;
  localparam logic [7:0] PATTERN_RESET = 8'h00;
  localparam int DIE_ADDR_BIT = 1;

  // ---------------------------------------------------------------
  // Host clock divider and chip select spacing, in core cycles minus one; opcode lengths in serial clocks
  // ---------------------------------------------------------------
  localparam logic [2:0] SCK_HALF_LAST = 3'h3;
  localparam logic [2:0] CS_SETUP_LAST = 3'h3;
  localparam logic [2:0] CS_HIGH_LAST = 3'h7;
  localparam logic [6:0] OP_CLKS_SPI = 7'h08;
  localparam logic [6:0] OP_CLKS_QUAD = 7'h02;

endpackage : fpc_pkg

// [core/fpc_link_if.sv]
// Serial flash link between host controller and flash device
`timescale 1ns/1ns
interface fpc_link_if;
  logic sck;
  logic cs_n;
  logic [3:0] h_o;
  logic [3:0] h_oe;
  logic [3:0] d_o;
  logic [3:0] d_oe;
  logic [3:0] io;

  // Resolved line level: device wins, then host, otherwise pulled high
  assign io = (d_oe & d_o) | (~d_oe & h_oe & h_o) | (~d_oe & ~h_oe);

  modport host (output sck, output cs_n, output h_o, output h_oe, input io);
  modport dev (input sck, input cs_n, input io, output d_o, output d_oe);
endinterface : fpc_link_if

// [core/fpc_flash_dev.sv]
// Flash device end: pattern and correction register command handling
`timescale 1ns/1ns
module fpc_flash_dev (
  input wire logic i_core_clk, // Core clock
  input wire logic i_sys_rst, // Asynchronous reset, active high
  fpc_link_if.dev lnk, // Serial link
  input wire logic i_four_line_mode, // Four-line instruction mode selected
  input wire logic i_pattern_en, // Pattern output in double-rate reads
  input wire logic i_corr_event, // Correction event pulse from array
  input wire logic i_corr_die, // Die of the correction event
  input wire logic [1:0] i_corr_addr, // Address indicator of the event
  output logic [7:0] o_pattern, // Volatile pattern register
  output logic [7:0] o_corr_die0, // Correction register, die 0
  output logic [7:0] o_corr_die1, // Correction register, die 1
  output logic o_wel, // Write enable latch
  output logic o_die_sel // Currently selected die
);

  // ---------------------------------------------------------------
  // State types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_prev;
    logic seen_fid;
    logic [7:0] pat;
    logic [1:0][7:0] corr;
    logic write_enable_latch;
    logic die;
    logic [7:0] snap_pat;
    logic [7:0] snap_corr;
    logic snap_quad;
    logic snap_pen;
  } fpc_core_t;

  typedef struct packed {
    logic fid;
    logic [5:0] cnt;
    logic [7:0] op;
    logic [7:0] sh;
    logic [7:0] dat;
    logic [3:0] dm;
    logic [3:0] pq;
    logic [3:0] poe;
  } fpc_lk_t;

  typedef struct packed {
    logic [3:0] nq;
    logic [3:0] noe;
  } fpc_out_t;

  fpc_core_t core_reg;
  fpc_core_t core_next;
  fpc_lk_t lk_reg;
  fpc_lk_t lk_next;
  fpc_out_t out_reg;
  fpc_out_t out_next;
  logic fresh_reg;
  logic frame_clr;
  logic [5:0] c0;
  logic [5:0] c1;
  logic [3:0] d0;
  logic [3:0] d1;
  logic [3:0] wr;
  logic [3:0] wf;
  logic [7:0] rise_sv;
  logic [7:0] fall_sv;
  logic [7:0] src;
  logic [7:0] sv;
  logic [3:0] dv;
  logic [3:0] ov;
  logic rd_op;
  logic [7:0] ev;
  logic [fpc_pkg::CORR_CNT_W-1:0] ecnt;

  // Frame state outside a frame is cleared by chip select high
  assign frame_clr = i_sys_rst | lnk.cs_n;

  // ---------------------------------------------------------------
  // Link side, rising edge: shift in opcode and data
  // ---------------------------------------------------------------
  // First edge of a frame; set while chip select is high
  always_ff @(posedge lnk.sck or posedge frame_clr) begin
    if (frame_clr) begin
      fresh_reg <= 1'b1;
    end else begin
      fresh_reg <= 1'b0;
    end
  end

  always_comb begin
    lk_next = lk_reg;
    c0 = fresh_reg ? 6'h00 : lk_reg.cnt;
    d0 = fresh_reg ? 4'h0 : lk_reg.dm;
    if (fresh_reg) begin
      lk_next.fid = ~lk_reg.fid;
    end
    rd_op = (c0 >= fpc_pkg::BYTE_BITS) &&
            (lk_reg.op == fpc_pkg::OP_READ_PATTERN || lk_reg.op == fpc_pkg::OP_READ_CORR);
    if (core_reg.snap_quad) begin
      lk_next.sh = {lk_reg.sh[3:0], lnk.io};
      c1 = c0 + fpc_pkg::STEP_QUAD;
    end else begin
      lk_next.sh = {lk_reg.sh[6:0], lnk.io[fpc_pkg::SI_LINE]};
      c1 = c0 + fpc_pkg::STEP_SPI;
    end
    if (c0 >= fpc_pkg::CNT_SAT) begin
      c1 = c0;
    end else if (c1 == fpc_pkg::BYTE_BITS) begin
      lk_next.op = lk_next.sh;
    end else if (c1 == fpc_pkg::DATA_BITS) begin
      lk_next.dat = lk_next.sh;
    end
    if (rd_op && c1 >= fpc_pkg::DATA_BITS) begin
      c1 = c1 - fpc_pkg::BYTE_BITS;
    end
    lk_next.cnt = c1;
    // Dummy clocks of a double-rate read follow the address
    d1 = d0;
    if (lk_reg.op == fpc_pkg::OP_DTR_READ && c0 >= fpc_pkg::ADDR_END && d0 != fpc_pkg::DM_MAX) begin
      d1 = d0 + 4'h1;
    end
    lk_next.dm = d1;
    wr = d1 - fpc_pkg::DM_WIN_LO;
    rise_sv = core_reg.snap_pat << {wr[1:0], 1'b0};
    if (core_reg.snap_pen && lk_reg.op == fpc_pkg::OP_DTR_READ && c0 >= fpc_pkg::ADDR_END &&
        d1 >= fpc_pkg::DM_WIN_LO && d1 <= fpc_pkg::DUMMY_CLKS) begin
      lk_next.pq = {4{rise_sv[7]}} ^ out_reg.nq;
      lk_next.poe = fpc_pkg::ALL_LINES;
    end else begin
      lk_next.pq = 4'h0;
      lk_next.poe = 4'h0;
    end
  end

  always_ff @(posedge lnk.sck or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lk_reg <= '0;
    end else begin
      lk_reg <= lk_next;
    end
  end

  // ---------------------------------------------------------------
  // Link side, falling edge: launch read data
  // ---------------------------------------------------------------
  always_comb begin
    out_next = '0;
    src = (lk_reg.op == fpc_pkg::OP_READ_PATTERN) ? core_reg.snap_pat : core_reg.snap_corr;
    sv = src << lk_reg.cnt[2:0];
    wf = lk_reg.dm - fpc_pkg::DM_WIN_LO;
    fall_sv = core_reg.snap_pat << {wf[1:0], 1'b1};
    dv = 4'h0;
    ov = 4'h0;
    if ((lk_reg.op == fpc_pkg::OP_READ_PATTERN || lk_reg.op == fpc_pkg::OP_READ_CORR) &&
        lk_reg.cnt >= fpc_pkg::BYTE_BITS) begin
      if (core_reg.snap_quad) begin
        dv = sv[7:4];
        ov = fpc_pkg::ALL_LINES;
      end else begin
        dv = {4{sv[7]}} & fpc_pkg::SO_MASK;
        ov = fpc_pkg::SO_MASK;
      end
    end else if (core_reg.snap_pen && lk_reg.op == fpc_pkg::OP_DTR_READ &&
                 lk_reg.dm >= fpc_pkg::DM_WIN_LO && lk_reg.dm <= fpc_pkg::DUMMY_CLKS) begin
      dv = {4{fall_sv[7]}};
      ov = fpc_pkg::ALL_LINES;
    end
    out_next.nq = dv ^ lk_reg.pq;
    out_next.noe = ov;
  end

  always_ff @(negedge lnk.sck or posedge frame_clr) begin
    if (frame_clr) begin
      out_reg <= '0;
    end else begin
      out_reg <= out_next;
    end
  end

  // Two-edge output pair; chip select gates the enable so a cut frame frees the bus
  assign lnk.d_o = out_reg.nq ^ lk_reg.pq;
  assign lnk.d_oe = (out_reg.noe | lk_reg.poe) & {4{~lnk.cs_n}};

  // ---------------------------------------------------------------
  // Core side: command completion at chip select rise
  // ---------------------------------------------------------------
  // Link fields are only read once chip select has risen, when no edge can move them
  always_comb begin
    core_next = core_reg;
    core_next.cs_s1 = lnk.cs_n;
    core_next.cs_s2 = core_reg.cs_s1;
    core_next.cs_prev = core_reg.cs_s2;
    // Snapshots frozen for the link while a frame runs
    if (core_reg.cs_s2) begin
      core_next.snap_pat = core_reg.pat;
      core_next.snap_corr = core_reg.corr[core_reg.die];
      core_next.snap_quad = i_four_line_mode;
      core_next.snap_pen = i_pattern_en;
    end
    if (core_reg.cs_s2 && !core_reg.cs_prev && lk_reg.fid != core_reg.seen_fid) begin
      core_next.seen_fid = lk_reg.fid;
      case (lk_reg.op)
        fpc_pkg::OP_WRITE_ENABLE: begin
          if (lk_reg.cnt == fpc_pkg::BYTE_BITS) begin
            core_next.write_enable_latch = 1'b1;
          end
        end
        fpc_pkg::OP_WRITE_PATTERN: begin
          if (core_reg.write_enable_latch && lk_reg.cnt == fpc_pkg::DATA_BITS) begin
            core_next.pat = lk_reg.dat;
            core_next.write_enable_latch = 1'b0;
          end
        end
        fpc_pkg::OP_WRITE_CORR: begin
          if (core_reg.write_enable_latch && lk_reg.cnt == fpc_pkg::DATA_BITS) begin
            core_next.corr[core_reg.die] = (lk_reg.dat & ~fpc_pkg::CORR_STICKY) |
                                           (core_reg.corr[core_reg.die] & fpc_pkg::CORR_STICKY);
            core_next.write_enable_latch = 1'b0;
          end
        end
        fpc_pkg::OP_CLEAR_CORR: begin
          if (lk_reg.cnt == fpc_pkg::BYTE_BITS) begin
            core_next.corr[core_reg.die] = core_reg.corr[core_reg.die] & ~fpc_pkg::CORR_STICKY;
          end
        end
        fpc_pkg::OP_DIE_READ: begin
          if (lk_reg.cnt >= fpc_pkg::DATA_BITS) begin
            core_next.die = lk_reg.dat[fpc_pkg::DIE_ADDR_BIT];
          end
        end
        default: begin
          core_next.write_enable_latch = core_reg.write_enable_latch;
        end
      endcase
    end
    // events set after a clear, so a same-cycle event survives
    ev = core_next.corr[i_corr_die];
    ecnt = ev[fpc_pkg::CORR_CNT_LSB +: fpc_pkg::CORR_CNT_W];
    if (i_corr_event) begin
      ev[fpc_pkg::CORR_EVENT_BIT] = 1'b1;
      // Counter fills as a thermometer so no bit ever falls back
      ev[fpc_pkg::CORR_CNT_LSB +: fpc_pkg::CORR_CNT_W] = ecnt | {ecnt[fpc_pkg::CORR_CNT_W-2:0], 1'b1};
      ev[fpc_pkg::CORR_ADDR_LSB +: fpc_pkg::CORR_ADDR_W] =
        ev[fpc_pkg::CORR_ADDR_LSB +: fpc_pkg::CORR_ADDR_W] | i_corr_addr;
      core_next.corr[i_corr_die] = ev;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      core_reg <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_prev: 1'b1, seen_fid: 1'b0,
                    pat: fpc_pkg::PATTERN_RESET, corr: {fpc_pkg::CORR_RESET, fpc_pkg::CORR_RESET},
                    write_enable_latch: 1'b0, die: 1'b0, snap_pat: fpc_pkg::PATTERN_RESET,
                    snap_corr: fpc_pkg::CORR_RESET, snap_quad: 1'b0, snap_pen: 1'b0};
    end else begin
      core_reg <= core_next;
    end
  end

  // User-side outputs straight from the core state
  assign o_pattern = core_reg.pat;
  assign o_corr_die0 = core_reg.corr[0];
  assign o_corr_die1 = core_reg.corr[1];
  assign o_wel = core_reg.write_enable_latch;
  assign o_die_sel = core_reg.die;

endmodule : fpc_flash_dev

// [core/fpc_flash_host.sv]
// Host end: issues one flash command frame per request and collects read bytes
`timescale 1ns/1ns
module fpc_flash_host (
  input wire logic i_core_clk, // Core clock
  input wire logic i_sys_rst, // Asynchronous reset, active high
  fpc_link_if.host lnk, // Serial link
  input wire logic i_cmd_valid, // Start a frame, taken while idle
  input wire logic [7:0] i_opcode, // Opcode byte
  input wire logic [31:0] i_wdata, // Bytes after the opcode, first in bits 31:24
  input wire logic [2:0] i_tx_len, // Bytes of i_wdata to send, 0..4
  input wire logic [3:0] i_dummy, // Dummy clocks with all lines released
  input wire logic [1:0] i_rx_len, // Bytes to receive, 0..2
  input wire logic i_four_line_mode, // Four-line transfer for this frame
  output logic o_busy, // Frame in progress
  output logic o_done, // One-cycle pulse when chip select rises
  output logic [15:0] o_rdata // Received bytes, last byte in bits 7:0
);

  typedef enum logic [1:0] {
    HST_IDLE = 2'b00,
    HST_SETUP = 2'b01,
    HST_SHIFT = 2'b10,
    HST_GAP = 2'b11
  } fpc_hst_t;

  typedef struct packed {
    fpc_hst_t st;
    logic cs_n;
    logic sck;
    logic [2:0] hc;
    logic [6:0] k;
    logic [6:0] txc;
    logic [6:0] rxs;
    logic [6:0] tot;
    logic quad;
    logic [39:0] sh;
    logic [3:0] dout;
    logic [3:0] oe;
    logic [3:0] io_s1;
    logic [3:0] io_s2;
    logic [15:0] rx;
    logic done;
    logic busy;
  } fpc_host_t;

  fpc_host_t h_reg;
  fpc_host_t h_next;

  // ---------------------------------------------------------------
  // Frame sequencer and clock divider
  // ---------------------------------------------------------------
  always_comb begin
    h_next = h_reg;
    h_next.io_s1 = lnk.io;
    h_next.io_s2 = h_reg.io_s1;
    h_next.done = 1'b0;
    case (h_reg.st)
      HST_IDLE: begin
        h_next.busy = 1'b0;
        if (i_cmd_valid) begin
          h_next.quad = i_four_line_mode;
          // four-line frames use quarter the clocks
          if (i_four_line_mode) begin
            h_next.txc = fpc_pkg::OP_CLKS_QUAD + 7'({i_tx_len, 1'b0});
            h_next.dout = i_opcode[7:4];
            h_next.oe = fpc_pkg::ALL_LINES;
            h_next.sh = {i_opcode[3:0], i_wdata, 4'h0};
            h_next.tot = 7'({i_rx_len, 1'b0});
          end else begin
            // MSB first on the input line
            h_next.txc = fpc_pkg::OP_CLKS_SPI + 7'({i_tx_len, 3'b000});
            h_next.dout = {3'b000, i_opcode[7]};
            h_next.oe = fpc_pkg::SI_MASK;
            h_next.sh = {i_opcode[6:0], i_wdata, 1'b0};
            h_next.tot = 7'({i_rx_len, 3'b000});
          end
          h_next.rxs = h_next.txc + 7'(i_dummy);
          h_next.tot = h_next.rxs + h_next.tot;
          h_next.k = 7'h00;
          h_next.hc = 3'h0;
          h_next.cs_n = 1'b0;
          h_next.busy = 1'b1;
          h_next.st = HST_SETUP;
        end
      end
      HST_SETUP: begin
        h_next.hc = h_reg.hc + 3'h1;
        if (h_reg.hc == fpc_pkg::CS_SETUP_LAST) begin
          h_next.hc = 3'h0;
          h_next.st = HST_SHIFT;
        end
      end
      HST_SHIFT: begin
        h_next.hc = h_reg.hc + 3'h1;
        if (h_reg.hc == fpc_pkg::SCK_HALF_LAST) begin
          h_next.hc = 3'h0;
          h_next.sck = ~h_reg.sck;
          if (!h_reg.sck) begin
            // Rising edge: count the clock, sample read data
            h_next.k = h_reg.k + 7'h01;
            if (h_reg.k >= h_reg.rxs) begin
              h_next.rx = h_reg.quad ? {h_reg.rx[11:0], h_reg.io_s2} :
                                       {h_reg.rx[14:0], h_reg.io_s2[fpc_pkg::SO_LINE]};
            end
          end else if (h_reg.k == h_reg.tot) begin
            // chip select rises right after last bit
            // same exact end for correction writes
            h_next.cs_n = 1'b1;
            h_next.oe = 4'h0;
            h_next.done = 1'b1;
            h_next.st = HST_GAP;
          end else if (h_reg.k < h_reg.txc) begin
            // Falling edge: launch next bit or nibble
            h_next.dout = h_reg.quad ? h_reg.sh[39:36] : {3'b000, h_reg.sh[39]};
            h_next.sh = h_reg.quad ? {h_reg.sh[35:0], 4'h0} : {h_reg.sh[38:0], 1'b0};
          end else begin
            // Release all lines before dummy clocks and read data
            h_next.oe = 4'h0;
          end
        end
      end
      HST_GAP: begin
        h_next.hc = h_reg.hc + 3'h1;
        if (h_reg.hc == fpc_pkg::CS_HIGH_LAST) begin
          h_next.hc = 3'h0;
          h_next.busy = 1'b0;
          h_next.st = HST_IDLE;
        end
      end
      default: begin
        h_next.st = HST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      h_reg <= '{st: HST_IDLE, cs_n: 1'b1, sck: 1'b0, hc: 3'h0, k: 7'h00, txc: 7'h00,
                 rxs: 7'h00, tot: 7'h00, quad: 1'b0, sh: 40'h00_0000_0000, dout: 4'h0,
                 oe: 4'h0, io_s1: 4'hF, io_s2: 4'hF, rx: 16'h0000, done: 1'b0, busy: 1'b0};
    end else begin
      h_reg <= h_next;
    end
  end

  // Link pins and user outputs straight from the state
  assign lnk.sck = h_reg.sck;
  assign lnk.cs_n = h_reg.cs_n;
  assign lnk.h_o = h_reg.dout;
  assign lnk.h_oe = h_reg.oe;
  assign o_busy = h_reg.busy;
  assign o_done = h_reg.done;
  assign o_rdata = h_reg.rx;

endmodule : fpc_flash_host

// [testbench/fpc_link_checker.sv]
// Concurrent checks on the serial link between host and device ends
`timescale 1ns/1ns
module fpc_link_checker (
  input wire logic i_core_clk, // Core clock
  input wire logic i_sys_rst, // Reset, active high
  input wire logic sck, // Serial clock
  input wire logic cs_n, // Chip select, active low
  input wire logic [3:0] h_o, // Host line data
  input wire logic [3:0] h_oe, // Host line enables
  input wire logic [3:0] d_o, // Device line data
  input wire logic [3:0] d_oe, // Device line enables
  input wire logic [3:0] io // Resolved lines
);
  // -------------------------------------------------------------
  // Frame tracking; opcode-based checks cover single-line frames only
  // -------------------------------------------------------------
  logic [5:0] rises;
  logic [7:0] op_sh;
  logic [7:0] so_sh;
  logic quad_seen;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  // Count rising edges, keep opcode and the last eight output bits
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rises <= 6'h00;
      quad_seen <= 1'b0;
      op_sh <= 8'h00;
      so_sh <= 8'h00;
    end else if (cs_n) begin
      rises <= 6'h00;
      quad_seen <= 1'b0;
    end else begin
      if (h_oe[3]) quad_seen <= 1'b1;
      if ($rose(sck)) begin
        if (rises != 6'h3F) rises <= rises + 6'h01; // Saturate, long reads must not wrap
        if (rises < 6'h08) op_sh <= {op_sh[6:0], io[0]};
        so_sh <= {so_sh[6:0], io[1]};
      end
    end
  end
  sequence s_high4;
    sck [*4];
  endsequence
  sequence s_then_low;
    s_high4 ##1 !sck;
  endsequence
  property p_idle_release; cs_n |-> d_oe == 4'h0; endproperty
  a_idle_release: assert property (p_idle_release) else $error("device drives while deselected");
  property p_write_release;
    !quad_seen && rises >= 6'h08 && (op_sh == 8'h4A || op_sh == 8'hB5) |-> d_oe == 4'h0;
  endproperty
  a_write_release: assert property (p_write_release) else $error("device drives during write");
  property p_so_drive;
    !cs_n && !quad_seen && rises >= 6'h09 && rises <= 6'h0F && (op_sh == 8'h41 || op_sh == 8'hB3) |-> d_oe[1];
  endproperty
  a_so_drive: assert property (p_so_drive) else $error("output not driven in read");
  property p_repeat;
    $rose(sck) && !quad_seen && op_sh == 8'h41 && rises >= 6'h10 |-> io[1] == so_sh[7];
  endproperty
  a_repeat: assert property (p_repeat) else $error("pattern did not repeat");
  property p_no_fight; (d_oe & h_oe) == 4'h0; endproperty
  a_no_fight: assert property (p_no_fight) else $error("both ends drive a line");
  property p_cs_hold; $rose(cs_n) |-> cs_n [*8]; endproperty
  a_cs_hold: assert property (p_cs_hold) else $error("deselect too short");
  property p_setup; $fell(cs_n) |-> (!sck) [*7]; endproperty
  a_setup: assert property (p_setup) else $error("clock too soon after select");
  property p_sck_shape; $rose(sck) |-> s_then_low; endproperty
  a_sck_shape: assert property (p_sck_shape) else $error("clock high phase wrong");
  property p_cs_rise_low; $rose(cs_n) |-> !sck && h_oe == 4'h0; endproperty
  a_cs_rise_low: assert property (p_cs_rise_low) else $error("frame ended mid clock");
endmodule : fpc_link_checker

// [testbench/testbench.sv]
// Self-checking bench joining host and device ends against an integer model
`timescale 1ns/1ns
module testbench;
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic cmd_valid = 1'b0, quad = 1'b0, pat_en = 1'b0, ev = 1'b0, ev_die = 1'b0;
  logic [7:0] op = 8'h00, b;
  logic [31:0] wd = 32'h0, lfsr = 32'h9E63;
  logic [2:0] txl = 3'h0;
  logic [3:0] dmy = 4'h0;
  logic [1:0] rxl = 2'h0, ev_addr = 2'h0;
  logic busy, done, write_enable_latch, die;
  logic [15:0] rdata;
  logic [7:0] pat, c0, c1;
  int err_count = 0, num_checks = 0, m_pat = 0, m_wel = 0, m_die = 0, cv;
  int m_corr [2] = '{0, 0};
  fpc_link_if lnk_if ();
  fpc_flash_host fpc_flash_host_inst (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .lnk(lnk_if),
    .i_cmd_valid(cmd_valid), .i_opcode(op), .i_wdata(wd), .i_tx_len(txl), .i_dummy(dmy), .i_rx_len(rxl),
    .i_four_line_mode(quad), .o_busy(busy), .o_done(done), .o_rdata(rdata));
  fpc_flash_dev fpc_flash_dev_inst (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .lnk(lnk_if),
    .i_four_line_mode(quad), .i_pattern_en(pat_en), .i_corr_event(ev), .i_corr_die(ev_die),
    .i_corr_addr(ev_addr), .o_pattern(pat), .o_corr_die0(c0), .o_corr_die1(c1), .o_wel(write_enable_latch), .o_die_sel(die));
  fpc_link_checker fpc_link_checker_inst (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .sck(lnk_if.sck),
    .cs_n(lnk_if.cs_n), .h_o(lnk_if.h_o), .h_oe(lnk_if.h_oe), .d_o(lnk_if.d_o), .d_oe(lnk_if.d_oe), .io(lnk_if.io));
  // Core clock, 100 MHz
  initial forever #5 i_core_clk = ~i_core_clk;
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [15:0] got, input int exp, input string what);
    num_checks++;
    if (got !== exp[15:0]) begin
      err_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp[15:0]);
    end
  endtask : chk
  // Compare every visible register with the model
  task automatic chk_regs;
    chk({8'h00, pat}, m_pat, "pattern");
    chk({8'h00, c0}, m_corr[0], "corr die0");
    chk({8'h00, c1}, m_corr[1], "corr die1");
    chk({15'h0, write_enable_latch}, m_wel, "wel");
    chk({15'h0, die}, m_die, "die");
  endtask : chk_regs
  // One whole frame, then the model applies what the device must accept
  task automatic frame(input logic [7:0] o, input logic [31:0] w, input int t, input int r);
    int n;
    int dn = 0;
    @(posedge i_core_clk);
    #1 op = o; wd = w; txl = t[2:0]; rxl = r[1:0]; cmd_valid = 1'b1;
    // Double-rate read stub: host releases four dummy clocks before its receive window
    dmy = (o == fpc_pkg::OP_DTR_READ) ? 4'h4 : 4'h0;
    @(posedge i_core_clk);
    #1 cmd_valid = 1'b0;
    // Busy is looked at off the edge, so a flop update never races the wait
    for (n = 0; n < 3000 && busy !== 1'b0; n++) begin
      @(posedge i_core_clk);
      #1 dn += done;
    end
    if (n == 3000) begin
      err_count++;
      $display("unexpected at %0t: frame hung", $time);
      print_verdict();
    end
    chk(16'(dn), 1, "done pulses");
    cv = m_corr[m_die];
    // Writes only with latch set and an exact one-byte body
    if (o == fpc_pkg::OP_WRITE_ENABLE && t == 0) m_wel = 1;
    if (o == fpc_pkg::OP_WRITE_PATTERN && t == 1 && m_wel == 1) begin m_pat = w[31:24]; m_wel = 0; end
    if (o == fpc_pkg::OP_WRITE_CORR && t == 1 && m_wel == 1) begin
      m_corr[m_die] = (cv & 8'h7E) | (w[31:24] & 8'h81);
      m_wel = 0;
    end
    if (o == fpc_pkg::OP_CLEAR_CORR && t == 0) m_corr[m_die] = cv & 8'h81;
    if (o == fpc_pkg::OP_DIE_READ && t >= 1) m_die = w[25];
    chk_regs();
  endtask : frame
  // Array reports one correction event; counter fills as a thermometer
  task automatic corr_event(input logic d, input logic [1:0] a);
    @(posedge i_core_clk);
    #1 ev = 1'b1; ev_die = d; ev_addr = a;
    @(posedge i_core_clk);
    #1 ev = 1'b0;
    cv = m_corr[d] | 8'h02 | (a << 5);
    m_corr[d] = cv | ((cv << 1) & 8'h18) | 8'h04;
  endtask : corr_event
  initial begin
    repeat (5) @(posedge i_core_clk);
    #1 i_sys_rst = 1'b0;
    chk_regs();
    for (int q = 0; q < 2; q++) begin
      quad = q[0];
      b = lfsr[7:0];
      lfsr = lfsr_next(lfsr);
      frame(fpc_pkg::OP_WRITE_PATTERN, {b, 24'h0}, 1, 0);
      frame(fpc_pkg::OP_WRITE_ENABLE, 32'h0, 0, 0);
      frame(fpc_pkg::OP_WRITE_PATTERN, {b, b, 16'h0}, 2, 0);
      frame(fpc_pkg::OP_WRITE_PATTERN, 32'h0, 0, 0);
      frame(fpc_pkg::OP_WRITE_PATTERN, {b, 24'h0}, 1, 0);
      frame(fpc_pkg::OP_READ_PATTERN, 32'h0, 0, 2);
      chk(rdata, m_pat * 257, "pattern read");
      // Single-line host sees falling halves: bits 6,4,2,0, pulled-high lines around the window
      if (q == 0) begin
        pat_en = 1'b1;
        frame(fpc_pkg::OP_DTR_READ, lfsr, 4, 1);
        chk({8'h00, rdata[7:0]}, {1'b1, m_pat[6], m_pat[4], m_pat[2], m_pat[0], 3'b111}, "dtr pattern");
      end
      for (int k = 0; k < 3; k++) begin
        corr_event(lfsr[3], lfsr[5:4]);
        lfsr = lfsr_next(lfsr);
      end
      for (int d = 0; d < 2; d++) begin
        frame(fpc_pkg::OP_DIE_READ, {6'h00, d[0], 1'b0, 24'h0}, 1, 0);
        frame(fpc_pkg::OP_READ_CORR, 32'h0, 0, 1);
        chk({8'h00, rdata[7:0]}, m_corr[d], "corr read");
      end
      frame(fpc_pkg::OP_WRITE_CORR, {8'hFF, 24'h0}, 1, 0);
      frame(fpc_pkg::OP_WRITE_ENABLE, 32'h0, 0, 0);
      frame(fpc_pkg::OP_WRITE_CORR, {lfsr[7:0], 24'h0}, 1, 0);
      frame(fpc_pkg::OP_READ_CORR, 32'h0, 0, 1);
      chk({8'h00, rdata[7:0]}, m_corr[m_die], "corr after write");
      frame(fpc_pkg::OP_CLEAR_CORR, 32'h0, 0, 0);
      frame(fpc_pkg::OP_READ_CORR, 32'h0, 0, 1);
      chk({8'h00, rdata[7:0]}, m_corr[m_die], "corr after clear");
      $display("test done: four-line mode %0d", q);
    end
    print_verdict();
  end
endmodule : testbench
